// *** hw/dma_req_pkg.sv ***
// shared constants, register map and types of the four-channel request control
// assumes a 40 MHz system clock and an axi4-lite register bus of 32 bits
package dma_req_pkg;
    localparam int NUM_CH = 4;
    localparam int ADDR_W = 8;
    localparam int COUNT_W = 16;
    // register byte offsets; channel n control sits at CTRL_BASE + 4*n
    localparam logic [7:0] CTRL_BASE = 8'h00;
    localparam logic [7:0] COUNT_BASE = 8'h10;
    localparam logic [7:0] REQSRC_OFF = 8'h20;
    localparam logic [7:0] STATUS_OFF = 8'h24;
    localparam logic [7:0] IRQ_STAT_OFF = 8'h28;
    localparam logic [7:0] IRQ_MASK_OFF = 8'h2C;
    // field positions in a channel control word; CYCLE_BIT sits in the status word
    localparam int ENABLE_BIT = 0;
    localparam int INIT_BIT = 2;
    localparam int TRIG_BIT = 3;
    localparam int TC_BIT = 7;
    localparam int PEND_BIT = 8;
    localparam int BUSY_BIT = 9;
    localparam int CYCLE_BIT = 10;
    // transfer cycle length: response plus read, idle, write
    localparam int XFER_CYCLES = 8;
    localparam int XFER_CNT_W = 4;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        XFER_IDLE = 2'b00,
        XFER_BUSY = 2'b01,
        XFER_DONE = 2'b10
    } xfer_state_e;

    typedef struct packed {
        logic enable;
        logic tc;
        logic pending;
    } chan_state_s;
endpackage

// *** hw/fixed_priority_pick.sv ***
// fixed priority picker, lowest index wins
// assumes a plain request vector, no clock
`timescale 1ns/1ps
`default_nettype none
module fixed_priority_pick #(
    parameter int WIDTH = 4
) (
    input wire logic [WIDTH-1:0] request,
    output logic [WIDTH-1:0] grant,
    output logic any
);
    always_comb begin
        grant = '0;
        for (int i = WIDTH - 1; i >= 0; i--) begin
            if (request[i]) begin
                grant = '0;
                grant[i] = 1'b1;
            end
        end
    end
    if (WIDTH < 1) begin : g_bad_width
        $error("picker width must be at least one");
    end
    assign any = |request;
endmodule
`default_nettype wire

// *** hw/dma_chan_state.sv ***
// per-channel enable, terminal count, pending request and transfer count
// assumes the arbiter grants only channels that are pending and enabled
`timescale 1ns/1ps
`default_nettype none
module dma_chan_state
    import dma_req_pkg::*;
#(
    parameter int CW = COUNT_W
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic request,
    input wire logic inCycle,
    input wire logic granted,
    input wire logic xferDone,
    input wire logic wrEnable,
    input wire logic wrEnableVal,
    input wire logic wrInit,
    input wire logic wrCount,
    input wire logic [CW-1:0] wrCountVal,
    input wire logic tcRead,
    input wire logic tcReadBlocked,
    output chan_state_s state,
    output logic [CW-1:0] count,
    output logic [CW-1:0] initialCount,
    output logic tcEvent
);
    logic enable_reg, enable_next;
    logic tc_reg, tc_next;
    logic pend_reg, pend_next;
    logic [CW-1:0] count_reg, count_next;
    logic [CW-1:0] init_reg, init_next;
    logic tcEv_reg, tcEv_next;
    logic lastXfer;

    assign lastXfer = xferDone && (count_reg == CW'(1));

    always_comb begin
        enable_next = enable_reg;
        tc_next = tc_reg;
        pend_next = pend_reg;
        count_next = count_reg;
        init_next = init_reg;
        tcEv_next = 1'b0;
        if (wrCount) begin
            count_next = wrCountVal;
            init_next = wrCountVal;
        end
        if (wrEnable)
            enable_next = wrEnableVal;
        // a request during this channel's own cycle is discarded
        if (request && enable_reg && !tc_reg && !inCycle && !pend_reg)
            pend_next = 1'b1;
        if (granted)
            pend_next = 1'b0;
        // reads clear the flag, but a read racing the set is lost
        if (tcRead && !tcReadBlocked)
            tc_next = 1'b0;
        if (xferDone)
            count_next = count_reg - CW'(1);
        if (lastXfer) begin
            enable_next = 1'b0;
            tc_next = 1'b1;
            tcEv_next = 1'b1;
            count_next = init_reg;
        end
        // initialise only takes while no cycle of this channel runs
        if (wrInit && !inCycle && !granted) begin
            enable_next = 1'b0;
            pend_next = 1'b0;
            tc_next = 1'b0;
            count_next = init_reg;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            enable_reg <= 1'b0;
            tc_reg <= 1'b0;
            pend_reg <= 1'b0;
            count_reg <= '0;
            init_reg <= '0;
            tcEv_reg <= 1'b0;
        end else begin
            enable_reg <= enable_next;
            tc_reg <= tc_next;
            pend_reg <= pend_next;
            count_reg <= count_next;
            init_reg <= init_next;
            tcEv_reg <= tcEv_next;
        end
    end

    assign state = '{enable: enable_reg, tc: tc_reg, pending: pend_reg};
    assign count = count_reg;
    assign initialCount = init_reg;
    assign tcEvent = tcEv_reg;
endmodule
`default_nettype wire

// *** hw/dma_channel_request_control.sv ***
// four-channel request acceptance, priority and channel control
// assumes axi4-lite software access and synchronous request pulses
//
// Overview of operation
// - a request for the channel now transferring is discarded, not queued
// - same-channel request dropped, coinciding other-channel request is taken
// - simultaneous idle requests: highest granted, others stay pending
// - fixed priority channel 0 highest, checked at every transfer cycle
// - reading terminal count clears it, except a read at certain timing
// - initialise stops channel; on success count reads the initial value
// - enable low halts the channel, enable high resumes it
// - at final count: enable clears, terminal count sets, end irq raised
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_request_control
    import dma_req_pkg::*;
#(
    parameter int CHANNELS = NUM_CH,
    parameter int CYCLE_LEN = XFER_CYCLES
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CHANNELS-1:0] peripheralRequest,
    output logic [CHANNELS-1:0] transferAck,
    output logic [CHANNELS-1:0] transferEndIrq,
    output logic irq
);
    // refuse sizes that the two-bit channel index and four-bit cycle counter cannot hold
    if (CHANNELS != NUM_CH) begin : g_bad_channels
        $error("channel count must be four");
    end
    if (CYCLE_LEN < 2 || CYCLE_LEN > 15) begin : g_bad_cycle
        $error("cycle length out of range");
    end

    xfer_state_e xst_reg, xst_next;
    logic [XFER_CNT_W-1:0] xcnt_reg, xcnt_next;
    logic [1:0] active_reg, active_next;
    logic [CHANNELS-1:0] ack_reg, ack_next;

    logic [7:0] awaddr_reg, awaddr_next, araddr_reg, araddr_next;
    logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
    logic haveAw_reg, haveAw_next, haveW_reg, haveW_next;
    logic wstrb0_reg, wstrb0_next;
    logic bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
    logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
    logic [CHANNELS-1:0] trigSel_reg, trigSel_next, swTrig;
    logic [CHANNELS-1:0] istat_reg, istat_next, imask_reg, imask_next;

    chan_state_s chState [CHANNELS];
    logic [COUNT_W-1:0] chCount [CHANNELS];
    logic [COUNT_W-1:0] chInit [CHANNELS];
    logic [CHANNELS-1:0] tcEv, pendVec, grant, inCycle, xferDone;
    logic [CHANNELS-1:0] wrEn, wrInit, wrCnt, tcRd, chReq;
    logic anyPend, doWrite, doRead;
    logic [1:0] wIdx, rIdx;

    // arbitration: pending and enabled channels compete when the bus is free
    always_comb begin
        for (int i = 0; i < CHANNELS; i++)
            pendVec[i] = chState[i].pending && chState[i].enable;
    end

    fixed_priority_pick #(.WIDTH(CHANNELS)) u_pick (
        .request(xst_reg == XFER_BUSY ? '0 : pendVec),
        .grant(grant),
        .any(anyPend)
    );

    // picker runs whenever a cycle can start, so priority is fresh each time
    always_comb begin
        xst_next = xst_reg;
        xcnt_next = xcnt_reg;
        active_next = active_reg;
        ack_next = '0;
        case (xst_reg)
            XFER_IDLE, XFER_DONE: begin
                xst_next = XFER_IDLE;
                if (anyPend) begin
                    xst_next = XFER_BUSY;
                    xcnt_next = XFER_CNT_W'(CYCLE_LEN - 1);
                    ack_next = grant;
                    for (int i = 0; i < CHANNELS; i++)
                        if (grant[i])
                            active_next = 2'(i);
                end
            end
            XFER_BUSY: begin
                if (xcnt_reg == '0)
                    xst_next = XFER_DONE;
                else
                    xcnt_next = xcnt_reg - 1'b1;
            end
            default: xst_next = XFER_IDLE;
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            xst_reg <= XFER_IDLE;
            xcnt_reg <= '0;
            active_reg <= '0;
            ack_reg <= '0;
        end else begin
            xst_reg <= xst_next;
            xcnt_reg <= xcnt_next;
            active_reg <= active_next;
            ack_reg <= ack_next;
        end
    end

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            // own channel busy drops its request; others still latch
            inCycle[i] = (xst_reg == XFER_BUSY) && (active_reg == 2'(i));
            xferDone[i] = (xst_reg == XFER_DONE) && (active_reg == 2'(i));
            chReq[i] = trigSel_reg[i] ? swTrig[i] : peripheralRequest[i];
        end
    end

    for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
        dma_chan_state u_ch (
            .clock(clock),
            .rst(rst),
            .request(chReq[g]),
            .inCycle(inCycle[g]),
            .granted(grant[g] && xst_reg != XFER_BUSY),
            .xferDone(xferDone[g]),
            .wrEnable(wrEn[g]),
            .wrEnableVal(wdata_reg[ENABLE_BIT]),
            .wrInit(wrInit[g]),
            .wrCount(wrCnt[g]),
            .wrCountVal(wdata_reg[COUNT_W-1:0]),
            .tcRead(tcRd[g]),
            .tcReadBlocked(xferDone[g]),
            .state(chState[g]),
            .count(chCount[g]),
            .initialCount(chInit[g]),
            .tcEvent(tcEv[g])
        );
    end

    // axi4-lite: address and data latched in either order, then one write
    assign doWrite = haveAw_reg && haveW_reg && !bvalid_reg;
    assign doRead = s_axi_arvalid && !rvalid_reg;
    assign wIdx = awaddr_reg[3:2];
    assign rIdx = s_axi_araddr[3:2];

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            // unaligned accesses only answer with an error, they touch nothing
            wrEn[i] = doWrite && wstrb0_reg && awaddr_reg[7:4] == 4'h0
                && awaddr_reg[1:0] == 2'b00 && wIdx == 2'(i);
            wrInit[i] = wrEn[i] && wdata_reg[INIT_BIT];
            swTrig[i] = wrEn[i] && wdata_reg[TRIG_BIT];
            wrCnt[i] = doWrite && awaddr_reg[7:4] == 4'h1
                && awaddr_reg[1:0] == 2'b00 && wIdx == 2'(i);
            tcRd[i] = doRead && s_axi_araddr[7:4] == 4'h0
                && s_axi_araddr[1:0] == 2'b00 && rIdx == 2'(i);
        end
    end

    always_comb begin
        haveAw_next = haveAw_reg;
        haveW_next = haveW_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb0_next = wstrb0_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        rvalid_next = rvalid_reg;
        rresp_next = rresp_reg;
        rdata_next = rdata_reg;
        trigSel_next = trigSel_reg;
        imask_next = imask_reg;
        // set beats clear so an end event is never lost
        istat_next = istat_reg | tcEv;
        if (s_axi_awvalid && s_axi_awready) begin
            haveAw_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            haveW_next = 1'b1;
            wdata_next = s_axi_wdata;
            // the strobe is only valid with the data beat, so keep it here
            wstrb0_next = s_axi_wstrb[0];
        end
        if (s_axi_bvalid && s_axi_bready)
            bvalid_next = 1'b0;
        if (doWrite) begin
            haveAw_next = 1'b0;
            haveW_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (awaddr_reg)
                REQSRC_OFF: trigSel_next = wdata_reg[CHANNELS-1:0];
                IRQ_STAT_OFF:
                    istat_next = (istat_reg & ~wdata_reg[CHANNELS-1:0]) | tcEv;
                IRQ_MASK_OFF: imask_next = wdata_reg[CHANNELS-1:0];
                default:
                    if (awaddr_reg[7:5] != 3'b000 || awaddr_reg[1:0] != 2'b00)
                        bresp_next = RESP_SLVERR;
            endcase
        end
        if (s_axi_rvalid && s_axi_rready)
            rvalid_next = 1'b0;
        if (doRead) begin
            rvalid_next = 1'b1;
            rresp_next = RESP_OKAY;
            rdata_next = '0;
            if (s_axi_araddr[1:0] != 2'b00)
                rresp_next = RESP_SLVERR;
            else if (s_axi_araddr[7:4] == 4'h0) begin
                rdata_next[ENABLE_BIT] = chState[rIdx].enable;
                rdata_next[TRIG_BIT] = trigSel_reg[rIdx];
                rdata_next[TC_BIT] = chState[rIdx].tc;
                rdata_next[PEND_BIT] = chState[rIdx].pending;
                rdata_next[BUSY_BIT] = inCycle[rIdx];
            end else if (s_axi_araddr[7:4] == 4'h1)
                rdata_next[COUNT_W-1:0] = chCount[rIdx];
            else
                case (s_axi_araddr)
                    REQSRC_OFF: rdata_next[CHANNELS-1:0] = trigSel_reg;
                    STATUS_OFF: begin
                        rdata_next[CHANNELS-1:0] = ack_reg;
                        rdata_next[CYCLE_BIT] = xst_reg == XFER_BUSY;
                    end
                    IRQ_STAT_OFF: rdata_next[CHANNELS-1:0] = istat_reg;
                    IRQ_MASK_OFF: rdata_next[CHANNELS-1:0] = imask_reg;
                    default: rresp_next = RESP_SLVERR;
                endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            haveAw_reg <= 1'b0;
            haveW_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb0_reg <= 1'b0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rresp_reg <= RESP_OKAY;
            rdata_reg <= '0;
            trigSel_reg <= '0;
            istat_reg <= '0;
            imask_reg <= '0;
        end else begin
            haveAw_reg <= haveAw_next;
            haveW_reg <= haveW_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb0_reg <= wstrb0_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rresp_reg <= rresp_next;
            rdata_reg <= rdata_next;
            trigSel_reg <= trigSel_next;
            istat_reg <= istat_next;
            imask_reg <= imask_next;
        end
    end

    assign s_axi_awready = !haveAw_reg;
    assign s_axi_wready = !haveW_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rresp = rresp_reg;
    assign s_axi_rdata = rdata_reg;
    assign transferAck = ack_reg;
    assign transferEndIrq = tcEv;
    assign irq = |(istat_reg & imask_reg);
endmodule
`default_nettype wire

// *** verif/dma_req_chk.sv ***
// port checker: bus handshakes, grant spacing and end pulses
// bound to the top module, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dma_req_chk #(
    parameter int CHANNELS = 4,
    parameter int CYCLE_LEN = 8
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [CHANNELS-1:0] transferAck,
    input wire logic [CHANNELS-1:0] transferEndIrq
);
    // edges since the last grant, saturating so idle time never wraps
    logic [7:0] gap_reg;
    logic [7:0] gap_next;
    always_comb begin
        gap_next = gap_reg;
        if (|transferAck) begin
            gap_next = 8'h01;
        end else if (gap_reg != 8'hff) begin
            gap_next = gap_reg + 8'h01;
        end
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            gap_reg <= 8'hff;
        end else begin
            gap_reg <= gap_next;
        end
    end
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    ack_single_a: assert property ($onehot0(transferAck))
        else $error("two grants at once");
    ack_gap_a: assert property (|transferAck |-> gap_reg >= CYCLE_LEN)
        else $error("grant inside a running cycle");
    end_pulse_a: assert property (
        |transferEndIrq |=> !(|transferEndIrq))
        else $error("end pulse longer than one cycle");
    end_delay_a: assert property (
        |transferEndIrq |-> gap_reg <= CYCLE_LEN + 8)
        else $error("end pulse without a recent grant");
    rd_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    rd_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    wr_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready
        && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("address taken while read pending");
    cover property (|transferAck);
    cover property (|transferEndIrq);
    cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind dma_channel_request_control dma_req_chk #(.CHANNELS(CHANNELS),
    .CYCLE_LEN(CYCLE_LEN)) chk (.clock, .rst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .transferAck,
    .transferEndIrq);
`default_nettype wire

// *** verif/req_source.sv ***
// peripheral request sources: one-cycle request per fire strobe
// halt stands for a source that software has stopped
`timescale 1ns/1ps
`default_nettype none
module req_source (
    input wire logic clock,
    input wire logic rst,
    input wire logic [3:0] fire,
    input wire logic [3:0] halt,
    output logic [3:0] peripheralRequest
);
    logic [3:0] req_reg;
    logic [3:0] req_next;
    // a stopped source raises nothing until restarted
    always_comb begin
        req_next = fire & ~halt;
    end
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            req_reg <= 4'h0;
        end else begin
            req_reg <= req_next;
        end
    end
    assign peripheralRequest = req_reg;
endmodule
`default_nettype wire

// *** verif/tb_dma_channel_request_control.sv ***
// bench: axi4-lite tasks, request sources, grant log
// assumes one clock; waits are cut by the cycle ceiling
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    miscompares++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_dma_channel_request_control;
    import dma_req_pkg::*;
    localparam int LEN = 4;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0000_0000;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [3:0] peripheralRequest;
    logic [3:0] transferAck;
    logic [3:0] transferEndIrq;
    logic irq;
    logic [3:0] fire = 4'h0;
    logic [3:0] halt = 4'h0;
    logic [3:0] ackLog[$];
    logic endSeen = 1'b0;
    logic [31:0] rdat;
    logic [1:0] rsp;
    logic [3:0] saved = 4'h0;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    dma_channel_request_control #(.CYCLE_LEN(LEN)) dut (.clock, .rst,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .peripheralRequest, .transferAck, .transferEndIrq,
        .irq);
    req_source src (.clock, .rst, .fire, .halt, .peripheralRequest);
    initial begin
        forever #12.5 clock = ~clock;
    end
    // pulses are sampled mid-cycle so edge updates have landed
    always @(negedge clock) begin
        if (|transferAck) ackLog.push_back(transferAck);
        if (transferEndIrq[3]) endSeen = 1'b1;
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ga;
        logic gw;
        logic ta;
        logic tw;
        ga = 1'b0;
        gw = 1'b0;
        @(posedge clock);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hf;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ga && gw)) begin
            @(negedge clock);
            ta = s_axi_awvalid && s_axi_awready;
            tw = s_axi_wvalid && s_axi_wready;
            @(posedge clock);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            ga = ga | ta;
            gw = gw | tw;
        end
        do @(negedge clock); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        @(posedge clock);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clock);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(negedge clock); while (!s_axi_arready);
        @(posedge clock);
        s_axi_arvalid <= 1'b0;
        do @(negedge clock); while (!s_axi_rvalid);
        rdat = s_axi_rdata;
        rsp = s_axi_rresp;
        @(posedge clock);
        s_axi_rready <= 1'b0;
    endtask
    task automatic pulse(input logic [3:0] m);
        @(posedge clock);
        fire <= m;
        @(posedge clock);
        fire <= 4'h0;
    endtask
    // the quiet tail shows that no extra grant follows
    task automatic settle(input int k);
        while (ackLog.size() < k) @(negedge clock);
        repeat (16) @(negedge clock);
    endtask
    initial begin
        repeat (3) @(posedge clock);
        rst <= 1'b0; // wait control is taken as set before any request
        rd(CTRL_BASE);
        `CHK(rdat, 32'h0000_0000)
        rd(IRQ_MASK_OFF);
        `CHK(rdat, 32'h0000_0000)
        rd(8'h40);
        `CHK(rsp, RESP_SLVERR)
        wr(8'h40, 32'h0000_0001);
        `CHK(rsp, RESP_SLVERR)
        wr(REQSRC_OFF, 32'h0000_0000); // peripheral sources, no ram target
        wr(IRQ_MASK_OFF, 32'h0000_0008);
        for (int n = 0; n < 4; n++) begin
            wr(COUNT_BASE + 8'(4 * n), (n == 3) ? 32'h1 : 32'h10);
            wr(CTRL_BASE + 8'(4 * n), 32'h1 << ENABLE_BIT);
        end
        pulse(4'h7);
        settle(3);
        `CHK({ackLog[0], ackLog[1], ackLog[2]}, 12'h124)
        ackLog.delete();
        pulse(4'h1);
        while (ackLog.size() < 1) @(negedge clock);
        pulse(4'h3);
        settle(2);
        `CHK(ackLog.size(), 2)
        `CHK({ackLog[0], ackLog[1]}, 8'h12)
        rd(COUNT_BASE);
        `CHK(rdat, 32'h0000_000E)
        ackLog.delete();
        pulse(4'h8);
        while (!endSeen) @(negedge clock);
        rd(CTRL_BASE + 8'h0C);
        `CHK(rdat & 32'h0000_0081, 32'h1 << TC_BIT)
        @(negedge clock);
        `CHK(irq, 1'b1)
        for (int k = 0; k < 3; k++) begin
            rd(CTRL_BASE + 8'h0C);
            `CHK(rdat[TC_BIT], 1'b0)
        end
        rd(IRQ_STAT_OFF);
        `CHK(rdat, 32'h0000_0008)
        wr(IRQ_STAT_OFF, 32'h0000_0008);
        @(negedge clock);
        `CHK(irq, 1'b0)
        ackLog.delete();
        wr(CTRL_BASE + 8'h04, 32'h0);
        wr(CTRL_BASE + 8'h04, 32'h0);
        pulse(4'h2);
        settle(0);
        `CHK(ackLog.size(), 0)
        wr(CTRL_BASE + 8'h04, 32'h1 << ENABLE_BIT);
        pulse(4'h2);
        settle(1);
        `CHK(ackLog[0], 4'h2)
        // software trigger on channel 0 through its control word
        ackLog.delete();
        wr(REQSRC_OFF, 32'h0000_0001);
        rd(REQSRC_OFF);
        `CHK(rdat, 32'h0000_0001)
        wr(CTRL_BASE, 32'h0000_0009);
        settle(1);
        `CHK(ackLog[0], 4'h1)
        halt <= 4'h4;
        rd(CTRL_BASE + 8'h08);
        `CHK(rdat[PEND_BIT], 1'b0)
        for (int n = 0; n < 4; n++) begin
            rd(CTRL_BASE + 8'(4 * n));
            saved[n] = rdat[ENABLE_BIT] && !rdat[TC_BIT];
        end
        wr(CTRL_BASE + 8'h08, 32'h0);
        wr(CTRL_BASE + 8'h08, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(CTRL_BASE + 8'h08, 32'h1 << INIT_BIT);
            rd(COUNT_BASE + 8'h08);
            if (rdat == 32'h10) break;
        end
        `CHK(rdat, 32'h0000_0010)
        for (int n = 0; n < 4; n++) begin
            if (n != 2)
                wr(CTRL_BASE + 8'(4 * n), 32'(saved[n]));
        end
        rd(CTRL_BASE);
        `CHK(rdat[ENABLE_BIT], 1'b1)
        tally_and_finish();
    end
endmodule
`default_nettype wire
